// ### logic/uefc_char_match.sv
// Received character compare against flow characters
`timescale 1ns/100ps
`default_nettype none
module uefc_char_match (
   input wire logic ref_clk_in, // Clock
   input wire logic rstn_in, // Sync reset, low
   input wire logic rx_valid_in, // Received char strobe
   input wire logic [7:0] rx_char_in, // Received char
   input wire logic [1:0] rx_sel_in, // Receive pair select
   input wire logic [7:0] resume1_in, // First resume char
   input wire logic [7:0] resume2_in, // Second resume char
   input wire logic [7:0] pause1_in, // First pause char
   input wire logic [7:0] pause2_in, // Second pause char
   output logic pause_hit_out, // Pause sequence seen, pulse
   output logic resume_hit_out, // Resume sequence seen, pulse
   output logic special_hit_out // Char equals second pause, pulse
);
   logic pend_pause, pend_resume, next_pend_pause, next_pend_resume;
   logic next_pause_hit, next_resume_hit, next_special_hit;

   // Next-state compare, bit 0 maps to char lsb
   always_comb begin
      next_pend_pause = pend_pause;
      next_pend_resume = pend_resume;
      next_pause_hit = 1'b0;
      next_resume_hit = 1'b0;
      next_special_hit = 1'b0;
      if (rx_valid_in) begin
         next_special_hit = (rx_char_in == pause2_in); // [RULE13]
         next_pend_pause = 1'b0;
         next_pend_resume = 1'b0;
         case (rx_sel_in)
            2'b10: begin
               next_pause_hit = (rx_char_in == pause1_in);
               next_resume_hit = (rx_char_in == resume1_in);
            end
            2'b01: begin
               next_pause_hit = (rx_char_in == pause2_in);
               next_resume_hit = (rx_char_in == resume2_in);
            end
            2'b11: begin
               // Two chars in sequence form one code [RULE3]
               next_pause_hit = pend_pause && (rx_char_in == pause2_in);
               next_resume_hit = pend_resume &&
                  (rx_char_in == resume2_in);
               next_pend_pause = (rx_char_in == pause1_in);
               next_pend_resume = (rx_char_in == resume1_in);
            end
            default: begin
            end
         endcase
      end
   end

   // Register compare results
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         pend_pause <= 1'b0;
         pend_resume <= 1'b0;
         pause_hit_out <= 1'b0;
         resume_hit_out <= 1'b0;
         special_hit_out <= 1'b0;
      end else begin
         pend_pause <= next_pend_pause;
         pend_resume <= next_pend_resume;
         pause_hit_out <= next_pause_hit;
         resume_hit_out <= next_resume_hit;
         special_hit_out <= next_special_hit;
      end
   end

   // Dual mode needs a prior first char
   dual_order_a: assert property ( // [RULE3]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (rx_valid_in && rx_sel_in == 2'b11 && !pend_pause)
      |=> !pause_hit_out)
      else $error("dual pause matched without first char");
endmodule
`default_nettype wire

// ### logic/uefc_pkg.sv
// Package of constants for the enhanced flow control block
package uefc_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] UEFC_OFS_SCRATCH = 4'h0;
   localparam logic [3:0] UEFC_OFS_FEATURE = 4'h1;
   localparam logic [3:0] UEFC_OFS_RESUME1 = 4'h2;
   localparam logic [3:0] UEFC_OFS_RESUME2 = 4'h3;
   localparam logic [3:0] UEFC_OFS_PAUSE1 = 4'h4;
   localparam logic [3:0] UEFC_OFS_PAUSE2 = 4'h5;
   localparam logic [3:0] UEFC_OFS_TRIGGER = 4'h6;
   localparam logic [3:0] UEFC_OFS_MODEM = 4'h7;
   localparam logic [3:0] UEFC_OFS_STATUS = 4'h8;
   localparam logic [3:0] UEFC_OFS_MASK = 4'h9;
   localparam logic [3:0] UEFC_OFS_FLOW = 4'hA;
   // Feature register field positions
   localparam int UEFC_FB_AUTO_CTS = 7;
   localparam int UEFC_FB_AUTO_RTS = 6;
   localparam int UEFC_FB_SPECIAL = 5;
   localparam int UEFC_FB_ENHANCE = 4;
   // Interrupt status bit positions
   localparam int UEFC_SB_TRIGGER = 0;
   localparam int UEFC_SB_PAUSE = 1;
   localparam int UEFC_SB_RESUME = 2;
   localparam int UEFC_SB_SPECIAL = 4;
   // Reset values
   localparam logic [7:0] UEFC_RST_SCRATCH = 8'hFF;
   localparam logic [7:0] UEFC_RST_ZERO = 8'h00;
   localparam logic [4:0] UEFC_RST_LEVEL = 5'h08;
   // Receive FIFO depth, for the level count
   localparam logic [5:0] UEFC_FIFO_DEPTH = 6'h20;
endpackage

// ### logic/uefc_top.sv
// Enhanced flow control: scratch, feature register, auto CTS/RTS
// Functional notes
// RULE1: Eight-bit scratch register reads back as written, no side effect.
// RULE2: Feature bits 0 to 3 select single or dual software flow control.
// RULE3: Dual mode treats two flow characters as one sequence.
// RULE4: Bit 7 enables auto CTS; resets to zero.
// RULE5: Auto CTS: transmit stops while cts_n high, resumes when low.
// RULE6: Bit 6 enables auto RTS; interrupt at programmed trigger level.
// RULE7: Auto RTS drives rts_n high at next trigger level up.
// RULE8: Auto RTS returns rts_n low below next lower level.
// RULE9: Auto RTS off: rts_n follows host modem control bit.
// RULE10: Auto RTS bit read shows hardware flow status.
// RULE11: Bit 5 enables special character detect; resets to zero.
// RULE12: Match on second pause char keeps char, sets status bit 4.
// RULE13: Stored char bit 0 compares with received char lsb.
// RULE14: Host clears bits 3..0 before enabling special detect.
// RULE15: Bit 4 gates enhanced bits; clear saves and zeroes them.
// RULE16: Bits 3:2 pick transmit chars, bits 1:0 pick receive compare.
// RULE17: Host does not send flow characters as data.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module uefc_top
   import uefc_pkg::*;
(
   input wire logic ref_clk_in, // 20 MHz clock
   input wire logic rstn_in, // Sync reset, low
   input wire logic [3:0] addr_in, // Register address
   input wire logic [7:0] wdata_in, // Write data
   input wire logic wr_in, // Write strobe
   input wire logic rd_in, // Read strobe
   output logic [7:0] rdata_out, // Read data, next cycle
   input wire logic rx_valid_in, // Char into receive FIFO
   input wire logic [7:0] rx_char_in, // That char
   input wire logic rx_pop_in, // Host unloads one char
   input wire logic cts_n_in, // Clear to send, low
   input wire logic tx_req_in, // Core wants to send
   output logic tx_go_out, // Transmit allowed
   output logic rts_n_out, // Request to send, low
   output logic [1:0] tx_sel_out, // Transmit pair select
   output logic [1:0] rx_sel_out, // Receive pair select
   output logic irq_out // Interrupt, high level
);
   // Register state
   logic [7:0] scratch, next_scratch;
   logic [7:0] feature, next_feature;
   logic [3:0] saved_enh, next_saved_enh;
   logic [7:0] resume1, next_resume1, resume2, next_resume2;
   logic [7:0] pause1, next_pause1, pause2, next_pause2;
   logic [4:0] trig_level, next_trig_level;
   logic host_rts, next_host_rts;
   logic [7:0] status, next_status, mask, next_mask;
   logic [7:0] next_rdata;
   logic [5:0] fill, next_fill;
   logic rts_hold, next_rts_hold, trig_seen, next_trig_seen;
   logic pause_hit, resume_hit, special_hit;
   logic tx_go, next_tx_go, rts_n, next_rts_n;
   logic [1:0] tx_sel, next_tx_sel, rx_sel, next_rx_sel;
   logic irq, next_irq;
   logic [7:0] events;
   logic enh_on;
   logic [5:0] up_level, down_level;

   // Address decode for register writes
   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      return a == o;
   endfunction

   assign enh_on = feature[UEFC_FB_ENHANCE];
   // Hysteresis bounds around the programmed level
   assign up_level = {1'b0, trig_level} + 6'h08;
   assign down_level = {1'b0, trig_level} - 6'h08;

   uefc_char_match u_match (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .rx_valid_in(rx_valid_in),
      .rx_char_in(rx_char_in),
      .rx_sel_in(rx_sel),
      .resume1_in(resume1),
      .resume2_in(resume2),
      .pause1_in(pause1),
      .pause2_in(pause2),
      .pause_hit_out(pause_hit),
      .resume_hit_out(resume_hit),
      .special_hit_out(special_hit)
   );

   // Events that set sticky status bits
   always_comb begin
      events = 8'h00;
      events[UEFC_SB_TRIGGER] = feature[UEFC_FB_AUTO_RTS] && !trig_seen &&
         (fill >= {1'b0, trig_level}); // [RULE6]
      events[UEFC_SB_PAUSE] = pause_hit;
      events[UEFC_SB_RESUME] = resume_hit;
      events[UEFC_SB_SPECIAL] = special_hit &&
         feature[UEFC_FB_SPECIAL]; // [RULE12]
   end

   // Register file next values
   always_comb begin
      next_scratch = scratch;
      next_feature = feature;
      next_saved_enh = saved_enh;
      next_resume1 = resume1;
      next_resume2 = resume2;
      next_pause1 = pause1;
      next_pause2 = pause2;
      next_trig_level = trig_level;
      next_host_rts = host_rts;
      next_mask = mask;
      next_status = status;
      if (wr_in) begin
         if (hit(addr_in, UEFC_OFS_SCRATCH)) begin
            next_scratch = wdata_in; // [RULE1]
         end
         if (hit(addr_in, UEFC_OFS_FEATURE)) begin
            // Low nibble always writable [RULE2] [RULE16]
            next_feature[3:0] = wdata_in[3:0];
            next_feature[UEFC_FB_ENHANCE] = wdata_in[UEFC_FB_ENHANCE];
            if (enh_on && !wdata_in[UEFC_FB_ENHANCE]) begin
               // Save current settings, then zero them [RULE15]
               next_saved_enh = {feature[7:5], 1'b0};
               next_feature[7:5] = 3'b000;
            end else if (!enh_on && wdata_in[UEFC_FB_ENHANCE]) begin
               next_feature[7:5] = saved_enh[3:1]; // [RULE15]
            end else if (enh_on) begin
               next_feature[7:5] = wdata_in[7:5]; // [RULE4] [RULE11]
            end
         end
         if (hit(addr_in, UEFC_OFS_RESUME1)) begin
            next_resume1 = wdata_in;
         end
         if (hit(addr_in, UEFC_OFS_RESUME2)) begin
            next_resume2 = wdata_in;
         end
         if (hit(addr_in, UEFC_OFS_PAUSE1)) begin
            next_pause1 = wdata_in;
         end
         if (hit(addr_in, UEFC_OFS_PAUSE2)) begin
            next_pause2 = wdata_in;
         end
         if (hit(addr_in, UEFC_OFS_TRIGGER)) begin
            next_trig_level = wdata_in[4:0];
         end
         if (hit(addr_in, UEFC_OFS_MODEM)) begin
            next_host_rts = wdata_in[0];
         end
         if (hit(addr_in, UEFC_OFS_MASK)) begin
            next_mask = wdata_in;
         end
         if (hit(addr_in, UEFC_OFS_STATUS)) begin
            next_status = status & ~wdata_in;
         end
      end
      // Set wins over a same-cycle clear
      next_status = next_status | events;
   end

   // Read mux, answered next cycle
   always_comb begin
      next_rdata = 8'h00;
      if (rd_in) begin
         case (addr_in)
            UEFC_OFS_SCRATCH: next_rdata = scratch; // [RULE1]
            UEFC_OFS_FEATURE: begin
               next_rdata = feature;
               // Bit 6 reads hardware flow state [RULE10]
               next_rdata[UEFC_FB_AUTO_RTS] = feature[UEFC_FB_AUTO_RTS] &&
                  !rts_hold;
            end
            UEFC_OFS_RESUME1: next_rdata = resume1;
            UEFC_OFS_RESUME2: next_rdata = resume2;
            UEFC_OFS_PAUSE1: next_rdata = pause1;
            UEFC_OFS_PAUSE2: next_rdata = pause2;
            UEFC_OFS_TRIGGER: next_rdata = {3'b000, trig_level};
            UEFC_OFS_MODEM: next_rdata = {7'h00, host_rts};
            UEFC_OFS_STATUS: next_rdata = status;
            UEFC_OFS_MASK: next_rdata = mask;
            UEFC_OFS_FLOW: next_rdata = {2'b00, fill};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // FIFO level tracking and RTS hysteresis
   always_comb begin
      next_fill = fill;
      if (rx_valid_in && !rx_pop_in && fill != UEFC_FIFO_DEPTH) begin
         next_fill = fill + 6'h01;
      end else if (rx_pop_in && !rx_valid_in && fill != 6'h00) begin
         next_fill = fill - 6'h01;
      end
      next_trig_seen = trig_seen;
      if (fill < {1'b0, trig_level}) begin
         next_trig_seen = 1'b0;
      end else if (events[UEFC_SB_TRIGGER]) begin
         next_trig_seen = 1'b1;
      end
      next_rts_hold = rts_hold;
      if (!feature[UEFC_FB_AUTO_RTS]) begin
         next_rts_hold = 1'b0;
      end else if (fill >= up_level) begin
         next_rts_hold = 1'b1; // [RULE7]
      end else if (fill < down_level) begin
         next_rts_hold = 1'b0; // [RULE8]
      end
   end

   // Pin outputs and interrupt
   always_comb begin
      // Host bit set means assert RTS (pin low) [RULE9]
      next_rts_n = feature[UEFC_FB_AUTO_RTS] ? next_rts_hold : !host_rts;
      // Gate transmit on CTS pin level [RULE5]
      next_tx_go = tx_req_in &&
         !(feature[UEFC_FB_AUTO_CTS] && cts_n_in);
      next_tx_sel = feature[3:2]; // [RULE16]
      next_rx_sel = feature[1:0]; // [RULE16]
      next_irq = |(next_status & mask);
   end

   // All state registers
   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         scratch <= UEFC_RST_SCRATCH;
         feature <= UEFC_RST_ZERO; // [RULE4] [RULE11]
         saved_enh <= 4'h0;
         resume1 <= UEFC_RST_ZERO;
         resume2 <= UEFC_RST_ZERO;
         pause1 <= UEFC_RST_ZERO;
         pause2 <= UEFC_RST_ZERO;
         trig_level <= UEFC_RST_LEVEL;
         host_rts <= 1'b0;
         status <= UEFC_RST_ZERO;
         mask <= UEFC_RST_ZERO;
         rdata_out <= UEFC_RST_ZERO;
         fill <= 6'h00;
         rts_hold <= 1'b0;
         trig_seen <= 1'b0;
         rts_n <= 1'b1;
         tx_go <= 1'b0;
         tx_sel <= 2'b00;
         rx_sel <= 2'b00;
         irq <= 1'b0;
      end else begin
         scratch <= next_scratch;
         feature <= next_feature;
         saved_enh <= next_saved_enh;
         resume1 <= next_resume1;
         resume2 <= next_resume2;
         pause1 <= next_pause1;
         pause2 <= next_pause2;
         trig_level <= next_trig_level;
         host_rts <= next_host_rts;
         status <= next_status;
         mask <= next_mask;
         rdata_out <= next_rdata;
         fill <= next_fill;
         rts_hold <= next_rts_hold;
         trig_seen <= next_trig_seen;
         rts_n <= next_rts_n;
         tx_go <= next_tx_go;
         tx_sel <= next_tx_sel;
         rx_sel <= next_rx_sel;
         irq <= next_irq;
      end
   end

   assign rts_n_out = rts_n;
   assign tx_go_out = tx_go;
   assign tx_sel_out = tx_sel;
   assign rx_sel_out = rx_sel;
   assign irq_out = irq;

   // Scratch read returns last write
   scratch_echo_a: assert property ( // [RULE1]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (wr_in && addr_in == UEFC_OFS_SCRATCH) ##1
      (rd_in && addr_in == UEFC_OFS_SCRATCH)
      |=> rdata_out == $past(wdata_in, 2))
      else $error("scratch did not read back");

   // CTS high blocks transmit
   cts_stop_a: assert property ( // [RULE5]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (feature[UEFC_FB_AUTO_CTS] && cts_n_in) |=> !tx_go_out)
      else $error("transmit while cts high");

   // CTS low lets transmit through
   cts_resume_a: assert property ( // [RULE5]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (tx_req_in && !cts_n_in) |=> tx_go_out)
      else $error("transmit not resumed");

   // Auto RTS raises pin at upper level
   rts_raise_a: assert property ( // [RULE7]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (feature[UEFC_FB_AUTO_RTS] && fill >= up_level)
      |=> rts_n_out)
      else $error("rts not raised at upper level");

   // Auto RTS drops pin below lower level
   rts_drop_a: assert property ( // [RULE8]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (feature[UEFC_FB_AUTO_RTS] && fill < down_level && fill < up_level)
      |=> !rts_n_out)
      else $error("rts not released");

   // Host RTS when auto disabled
   rts_host_a: assert property ( // [RULE9]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      !feature[UEFC_FB_AUTO_RTS] |=> rts_n_out == !$past(host_rts))
      else $error("rts not under host control");

   // Special match sets status bit 4
   special_flag_a: assert property ( // [RULE12]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (rx_valid_in && rx_char_in == pause2 && feature[UEFC_FB_SPECIAL])
      ##1 feature[UEFC_FB_SPECIAL]
      |=> status[UEFC_SB_SPECIAL])
      else $error("special char not flagged");

   // Clearing enhance bit zeroes upper bits
   enh_latch_a: assert property ( // [RULE15]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (wr_in && addr_in == UEFC_OFS_FEATURE && enh_on &&
       !wdata_in[UEFC_FB_ENHANCE]) |=> feature[7:5] == 3'b000)
      else $error("enhanced bits not latched off");

   // Trigger event raises status
   trig_irq_a: assert property ( // [RULE6]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      events[UEFC_SB_TRIGGER] |=> status[UEFC_SB_TRIGGER])
      else $error("trigger event lost");

   // Transmit pair select follows feature bits 3:2
   sel_follow_a: assert property ( // [RULE2]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      1'b1 |=> tx_sel_out == $past(feature[3:2]))
      else $error("transmit select mismatch");

   // Bit 6 reads low while flow is held
   flow_read_a: assert property ( // [RULE10]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (rd_in && addr_in == UEFC_OFS_FEATURE && rts_hold)
      |=> !rdata_out[UEFC_FB_AUTO_RTS])
      else $error("feature bit 6 ignores flow hold");

   // Interrupt follows unmasked status
   irq_level_a: assert property ( // [RULE6]
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (|(next_status & mask)) |=> irq_out)
      else $error("interrupt not raised");
endmodule
`default_nettype wire

// ### sim/test_uart_enhanced_flow_control.sv
// Self-checking bench for the enhanced flow control block
`timescale 1ns/100ps
`default_nettype none
module test_uart_enhanced_flow_control;
   import uefc_pkg::*;
   logic clk, rstn, wr, rd, pop, tx_req, cts_n, rx_valid;
   logic tx_go, rts_n, irq;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, rx_char;
   logic [1:0] tx_sel, rx_sel;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;

   uefc_top i_dut (
      .ref_clk_in(clk),
      .rstn_in(rstn),
      .addr_in(addr),
      .wdata_in(wdata),
      .wr_in(wr),
      .rd_in(rd),
      .rdata_out(rdata),
      .rx_valid_in(rx_valid),
      .rx_char_in(rx_char),
      .rx_pop_in(pop),
      .cts_n_in(cts_n),
      .tx_req_in(tx_req),
      .tx_go_out(tx_go),
      .rts_n_out(rts_n),
      .tx_sel_out(tx_sel),
      .rx_sel_out(rx_sel),
      .irq_out(irq)
   );

   uefc_remote_model i_remote (
      .clk_in(clk),
      .cts_n_out(cts_n),
      .rx_valid_out(rx_valid),
      .rx_char_out(rx_char)
   );

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         $display("timeout after %0d cycles", cycles);
         stop_test();
      end
   end

   task automatic stop_test();
      $display("compares %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One-cycle write strobe
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read strobe, data sampled in the following cycle only
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp,
                         input string what);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask

   // Host unloads one char
   task automatic pop_one();
      @(posedge clk);
      pop <= 1'b1;
      @(posedge clk);
      pop <= 1'b0;
   endtask

   // Main sequence
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      pop = 1'b0;
      tx_req = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      settle(1);
      // Reset state and an unmapped address
      chk("rts_n reset", 8'h01, {7'h00, rts_n});
      chk("irq reset", 8'h00, {7'h00, irq});
      rd_chk(UEFC_OFS_SCRATCH, UEFC_RST_SCRATCH, "scratch reset");
      rd_chk(UEFC_OFS_FEATURE, 8'h00, "feature reset");
      rd_chk(4'hB, 8'h00, "unmapped read");
      // Scratch readback, no side effect
      wr_reg(UEFC_OFS_SCRATCH, 8'h5A);
      rd_chk(UEFC_OFS_SCRATCH, 8'h5A, "scratch");
      wr_reg(UEFC_OFS_SCRATCH, 8'hA5);
      rd_chk(UEFC_OFS_SCRATCH, 8'hA5, "scratch");
      // Write then read with no gap between strobes
      @(posedge clk);
      addr <= UEFC_OFS_SCRATCH;
      wdata <= 8'h3C;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("scratch back to back", 8'h3C, rdata);
      rd_chk(UEFC_OFS_FEATURE, 8'h00, "feature untouched");
      // Enhanced bits gated by bit 4
      wr_reg(UEFC_OFS_FEATURE, 8'hE0);
      rd_chk(UEFC_OFS_FEATURE, 8'h00, "feature gated");
      wr_reg(UEFC_OFS_FEATURE, 8'h10);
      wr_reg(UEFC_OFS_FEATURE, 8'h90);
      rd_chk(UEFC_OFS_FEATURE, 8'h90, "feature auto cts");
      // Auto CTS pauses and resumes the transmitter
      @(posedge clk);
      tx_req <= 1'b1;
      i_remote.set_cts(1'b1);
      settle(3);
      chk("tx_go cts high", 8'h00, {7'h00, tx_go});
      i_remote.set_cts(1'b0);
      settle(3);
      chk("tx_go cts low", 8'h01, {7'h00, tx_go});
      i_remote.set_cts(1'b1);
      wr_reg(UEFC_OFS_FEATURE, 8'h00);
      settle(3);
      chk("tx_go latched off", 8'h01, {7'h00, tx_go});
      rd_chk(UEFC_OFS_FEATURE, 8'h00, "feature latched");
      wr_reg(UEFC_OFS_FEATURE, 8'h10);
      settle(3);
      chk("tx_go restored", 8'h00, {7'h00, tx_go});
      i_remote.set_cts(1'b0);
      // Every transmit and receive selection code
      for (int i = 0; i < 4; i++) begin
         wr_reg(UEFC_OFS_FEATURE, {4'h1, 2'(i), ~2'(i)});
         settle(3);
         chk("tx_sel", {6'h00, 2'(i)}, {6'h00, tx_sel});
         chk("rx_sel", {6'h00, ~2'(i)}, {6'h00, rx_sel});
      end
      // Host controlled request to send
      wr_reg(UEFC_OFS_MODEM, 8'h01);
      settle(3);
      chk("rts_n host on", 8'h00, {7'h00, rts_n});
      wr_reg(UEFC_OFS_MODEM, 8'h00);
      settle(3);
      chk("rts_n host off", 8'h01, {7'h00, rts_n});
      // Auto RTS with trigger 16: hold at 24, release below 8
      wr_reg(UEFC_OFS_TRIGGER, 8'h10);
      wr_reg(UEFC_OFS_MASK, 8'h01);
      wr_reg(UEFC_OFS_FEATURE, 8'h50);
      for (int k = 0; k < 16; k++) begin
         i_remote.send(8'h40 + 8'(k));
      end
      settle(4);
      rd_chk(UEFC_OFS_STATUS, 8'h01, "trigger status");
      chk("irq trigger", 8'h01, {7'h00, irq});
      for (int k = 0; k < 8; k++) begin
         i_remote.send(8'h60 + 8'(k));
      end
      settle(4);
      rd_chk(UEFC_OFS_FLOW, 8'h18, "fill count");
      chk("rts_n held", 8'h01, {7'h00, rts_n});
      rd_chk(UEFC_OFS_FEATURE, 8'h10, "feature while held");
      for (int k = 0; k < 16; k++) begin
         pop_one();
      end
      settle(4);
      chk("rts_n at lower level", 8'h01, {7'h00, rts_n});
      pop_one();
      settle(4);
      chk("rts_n released", 8'h00, {7'h00, rts_n});
      rd_chk(UEFC_OFS_FEATURE, 8'h50, "feature released");
      // Special char against second pause char, bit 0 is the lsb
      wr_reg(UEFC_OFS_FEATURE, 8'h10);
      wr_reg(UEFC_OFS_FEATURE, 8'h30);
      wr_reg(UEFC_OFS_PAUSE2, 8'h13);
      wr_reg(UEFC_OFS_MASK, 8'h10);
      wr_reg(UEFC_OFS_STATUS, 8'hFF);
      i_remote.send(8'hC8);
      settle(5);
      rd_chk(UEFC_OFS_STATUS, 8'h00, "reversed char");
      i_remote.send(8'h13);
      settle(5);
      rd_chk(UEFC_OFS_STATUS, 8'h10, "special status");
      chk("irq special", 8'h01, {7'h00, irq});
      rd_chk(UEFC_OFS_FLOW, 8'h09, "special kept");
      wr_reg(UEFC_OFS_STATUS, 8'h10);
      settle(3);
      chk("irq cleared", 8'h00, {7'h00, irq});
      // Dual pause chars form one two-char sequence
      wr_reg(UEFC_OFS_FEATURE, 8'h13);
      wr_reg(UEFC_OFS_PAUSE1, 8'h21);
      wr_reg(UEFC_OFS_MASK, 8'h02);
      i_remote.send(8'h21);
      i_remote.send(8'h40);
      settle(5);
      rd_chk(UEFC_OFS_STATUS, 8'h00, "broken sequence");
      i_remote.send(8'h21);
      i_remote.send(8'h13);
      settle(5);
      rd_chk(UEFC_OFS_STATUS, 8'h02, "pause sequence");
      chk("irq pause", 8'h01, {7'h00, irq});
      // Single first pair compares one char alone
      wr_reg(UEFC_OFS_STATUS, 8'hFF);
      wr_reg(UEFC_OFS_FEATURE, 8'h12);
      i_remote.send(8'h21);
      settle(5);
      rd_chk(UEFC_OFS_STATUS, 8'h02, "single pause");
      stop_test();
   end
endmodule
`default_nettype wire

// ### sim/uefc_remote_model.sv
// Remote serial peer driving the clear to send and receive lines
`timescale 1ns/100ps
`default_nettype none
module uefc_remote_model (
   input wire logic clk_in, // Bench clock
   output logic cts_n_out, // Clear to send, low
   output logic rx_valid_out, // Char arrives
   output logic [7:0] rx_char_out // Arriving char
);
   // Idle lines at time zero
   initial begin
      cts_n_out = 1'b0;
      rx_valid_out = 1'b0;
      rx_char_out = 8'h00;
   end

   // One char per strobe; once released the data shows its inverse
   task automatic send(input logic [7:0] c);
      @(posedge clk_in);
      rx_valid_out <= 1'b1;
      rx_char_out <= c;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_char_out <= ~c;
   endtask

   // Remote pauses or releases our transmitter
   task automatic set_cts(input logic v);
      @(posedge clk_in);
      cts_n_out <= v;
   endtask
endmodule
`default_nettype wire
